// *** shared/clk_pkg.sv ***
// Constants, register map and state codes for the stop-state clock selector.
package clk_pkg;

   // Register addresses on the special-function register port.
   localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
   localparam logic [7:0] CLK_CTRL_ADDR = 8'h8E;
   localparam logic [7:0] EXT_FLAG_ADDR = 8'h91;

   // Values after reset.
   localparam logic [7:0] PWR_CTRL_RESET = 8'h00;
   localparam logic [7:0] CLK_CTRL_RESET = 8'h01;
   localparam logic [3:0] EXT_IRQ_RESET = 4'h0;

   // Field positions in the power control register.
   localparam int IDLE_BIT = 0;
   localparam int STOP_BIT = 1;

   // Field positions in the clock control register.
   localparam int TIMER0_RATE_BIT = 3;
   localparam int TIMER_COUNT = 3;

   // Field positions in the extended flag register.
   localparam int BANDGAP_BIT = 0;
   localparam int RING_SELECT_BIT = 1;
   localparam int RING_ACTIVE_BIT = 2;
   localparam int EXT_IRQ_LSB = 4;

   // Divider widths and periods, in oscillator clocks.
   localparam int DIV_W = 4;
   localparam logic [3:0] MACHINE_CYCLE_CLOCKS = 4'h4;
   localparam logic [3:0] TIMER_SLOW_CLOCKS = 4'hC;
   localparam logic [3:0] TIMER_FAST_CLOCKS = 4'h4;

   // Crystal clocks counted before the crystal is trusted again.
   localparam int unsigned WARMUP_CLOCKS_DEFAULT = 65536;

   // Clock-source states, one-hot.
   typedef enum logic [4:0] {
      ST_RUN_XTAL  = 5'h01,
      ST_STOP      = 5'h02,
      ST_XTAL_WARM = 5'h04,
      ST_RUN_RING  = 5'h08,
      ST_HANDOVER  = 5'h10
   } clk_state_t;

endpackage

// *** shared/tick_div_if.sv ***
// Interface between the selector and a clock-tick divider.
`timescale 1ns/1ps
interface tick_div_if;
   import clk_pkg::*;

   logic step;
   logic restart;
   logic [DIV_W-1:0] period;
   logic pulse;

   modport divider (input step, input restart, input period, output pulse);
   modport user (output step, output restart, output period, input pulse);
endinterface

// *** logic/tick_divider.sv ***
// Divider that gives one pulse for every period of input clock ticks.
`timescale 1ns/1ps
module tick_divider (
   input wire logic clk_i,
   input wire logic reset_i,
   tick_div_if.divider div
);
   import clk_pkg::*;

   logic [DIV_W-1:0] cnt_q;
   logic pulse_q;

   // Tick counter; it wraps on the last tick and also if the period shrinks below it.
   always_ff @(posedge clk_i) begin
      if (reset_i || div.restart) begin
         cnt_q <= '0;
      end else if (div.step) begin
         if (cnt_q >= div.period - 4'h1) begin
            cnt_q <= '0;
         end else begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end

   // One pulse on the first tick of every period, so exactly one per period.
   always_ff @(posedge clk_i) begin
      if (reset_i || div.restart) begin
         pulse_q <= 1'b0;
      end else begin
         pulse_q <= div.step && (cnt_q == '0);
      end
   end

   assign div.pulse = pulse_q;
endmodule

// *** logic/stop_wake_ring_clock_select.sv ***
// Clock-source selector for stop-state exit, with machine-cycle and timer rate dividers.
//
// Operation
// RULE_01 - Stop state turns off crystal oscillator and all clocks; crystal restarts afterwards.
// RULE_02 - Ring oscillator is used only when stop is left through an interrupt.
// RULE_03 - Ring select is clear after reset, so stop exit waits for crystal.
// RULE_04 - Ring select bit 1 at register 91h makes stop exit run from ring.
// RULE_05 - Running on ring, switch to crystal after 65,536 crystal clocks counted.
// RULE_06 - Stop re-entered before handover turns every clock off, ring included.
// RULE_07 - Ring-active flag, bit 2 of register 91h, reads one while ring clocks core.
// RULE_08 - Software avoids serial transfers and precise timing while ring flag is set.
// RULE_09 - Machine cycle is four clocks with exactly one address-latch pulse each.
// RULE_10 - Timers advance every 12 clocks by default, or every 4 when selected.
// RULE_11 - Handover completion clears ring flag and switches source without a glitch.
`timescale 1ns/1ps
module stop_wake_ring_clock_select #(
   parameter int unsigned WARMUP_CLOCKS = clk_pkg::WARMUP_CLOCKS_DEFAULT
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_rd_i,
   output logic [7:0] sfr_rdata_o,
   input wire logic wake_irq_i,
   input wire logic xtal_i,
   input wire logic ring_i,
   output logic xtal_osc_en_o,
   output logic ring_osc_en_o,
   output logic core_clk_en_o,
   output logic cpu_clk_en_o,
   output logic core_on_ring_o,
   output logic stop_o,
   output logic ale_o,
   output logic [clk_pkg::TIMER_COUNT-1:0] timer_tick_o
);
   import clk_pkg::*;

   localparam int CNT_W = $clog2(WARMUP_CLOCKS);
   localparam logic [CNT_W-1:0] WARM_LAST = CNT_W'(WARMUP_CLOCKS - 1);

   clk_state_t state_q;
   clk_state_t state_d;
   logic [2:0] xtal_sync_q;
   logic [2:0] ring_sync_q;
   logic xtal_tick;
   logic ring_tick;
   logic core_tick;
   logic [CNT_W-1:0] warm_cnt_q;
   logic warm_done;
   logic pwr_wr;
   logic clk_wr;
   logic ext_wr;
   logic stop_req;
   logic [7:0] pwr_ctrl_q;
   logic [7:0] clk_ctrl_q;
   logic [3:0] ext_irq_q;
   logic bandgap_q;
   logic ring_select_q;
   logic ring_flag_q;
   logic [7:0] rdata_q;
   logic xtal_osc_en_q;
   logic ring_osc_en_q;
   logic core_clk_en_q;
   logic cpu_clk_en_q;
   logic stop_q;
   logic [TIMER_COUNT-1:0] timer_pulse;

   // Both oscillator pins come from outside and pass two flip-flops before use.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         xtal_sync_q <= 3'h0;
         ring_sync_q <= 3'h0;
      end else begin
         xtal_sync_q <= {xtal_sync_q[1:0], xtal_i};
         ring_sync_q <= {ring_sync_q[1:0], ring_i};
      end
   end

   // Rising edges of the synchronised oscillators are the oscillator clocks.
   assign xtal_tick = xtal_sync_q[1] && !xtal_sync_q[2];
   assign ring_tick = ring_sync_q[1] && !ring_sync_q[2];

   // Register port decode.
   assign pwr_wr = sfr_wr_i && (sfr_addr_i == PWR_CTRL_ADDR);
   assign clk_wr = sfr_wr_i && (sfr_addr_i == CLK_CTRL_ADDR);
   assign ext_wr = sfr_wr_i && (sfr_addr_i == EXT_FLAG_ADDR);
   assign stop_req = pwr_wr && sfr_wdata_i[STOP_BIT];

   // The warm-up interval ends on the last of the counted crystal clocks.
   assign warm_done = xtal_tick && (warm_cnt_q == WARM_LAST);

   // Next clock-source state.
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_RUN_XTAL: begin
            if (stop_req) begin
               state_d = ST_STOP; // [RULE_01]
            end
         end
         ST_STOP: begin
            // Only an interrupt can leave stop here; reset leaves it through reset_i.
            if (wake_irq_i) begin
               if (ring_select_q) begin
                  state_d = ST_RUN_RING; // [RULE_02] [RULE_04]
               end else begin
                  state_d = ST_XTAL_WARM; // [RULE_03]
               end
            end
         end
         ST_XTAL_WARM: begin
            if (warm_done) begin
               state_d = ST_RUN_XTAL; // [RULE_01]
            end
         end
         ST_RUN_RING: begin
            if (stop_req) begin
               state_d = ST_STOP; // [RULE_06]
            end else if (warm_done) begin
               state_d = ST_HANDOVER; // [RULE_05]
            end
         end
         ST_HANDOVER: begin
            // The core gets no ticks here, so the source changes with no short pulse.
            if (stop_req) begin
               state_d = ST_STOP; // [RULE_06]
            end else if (xtal_tick) begin
               state_d = ST_RUN_XTAL; // [RULE_11]
            end
         end
         default: begin
            state_d = ST_RUN_XTAL;
         end
      endcase
   end

   // Clock-source state register.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_q <= ST_RUN_XTAL;
      end else begin
         state_q <= state_d;
      end
   end

   // Crystal clocks counted since the oscillator was restarted.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         warm_cnt_q <= '0;
      end else if (state_q == ST_STOP) begin
         warm_cnt_q <= '0;
      end else if (xtal_tick && (state_q == ST_XTAL_WARM || state_q == ST_RUN_RING)) begin
         warm_cnt_q <= warm_cnt_q + 1'b1; // [RULE_05]
      end
   end

   // Core clock tick from the selected source; none while stopped, warming up or switching.
   always_comb begin
      core_tick = 1'b0;
      if (state_q == ST_RUN_XTAL) begin
         core_tick = xtal_tick;
      end else if (state_q == ST_RUN_RING) begin
         core_tick = ring_tick; // [RULE_04]
      end
   end

   // Power control register; the stop bit drops again once stop is left.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pwr_ctrl_q <= PWR_CTRL_RESET;
      end else if (pwr_wr) begin
         pwr_ctrl_q <= sfr_wdata_i;
      end else begin
         if (state_q == ST_STOP && state_d != ST_STOP) begin
            pwr_ctrl_q[STOP_BIT] <= 1'b0;
         end
         if (wake_irq_i) begin
            pwr_ctrl_q[IDLE_BIT] <= 1'b0;
         end
      end
   end

   // Clock control register with the timer rate selects.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         clk_ctrl_q <= CLK_CTRL_RESET;
      end else if (clk_wr) begin
         clk_ctrl_q <= sfr_wdata_i;
      end
   end

   // Writable fields of the extended flag register.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ext_irq_q <= EXT_IRQ_RESET;
         bandgap_q <= 1'b0;
         ring_select_q <= 1'b0; // [RULE_03]
      end else if (ext_wr) begin
         ext_irq_q <= sfr_wdata_i[EXT_IRQ_LSB +: 4];
         bandgap_q <= sfr_wdata_i[BANDGAP_BIT];
         ring_select_q <= sfr_wdata_i[RING_SELECT_BIT]; // [RULE_04]
      end
   end

   // Ring-active flag; hardware alone sets and clears it.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ring_flag_q <= 1'b0;
      end else begin
         ring_flag_q <= (state_d == ST_RUN_RING) || (state_d == ST_HANDOVER); // [RULE_07] [RULE_11]
      end
   end

   // Read data one cycle after the read strobe; unmapped addresses read zero.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdata_q <= 8'h00;
      end else if (sfr_rd_i) begin
         unique case (sfr_addr_i)
            PWR_CTRL_ADDR: rdata_q <= pwr_ctrl_q;
            CLK_CTRL_ADDR: rdata_q <= clk_ctrl_q;
            EXT_FLAG_ADDR: rdata_q <= {ext_irq_q, 1'b0, ring_flag_q, ring_select_q, bandgap_q}; // [RULE_07]
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // Oscillator enables and the stop output follow the next state.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         xtal_osc_en_q <= 1'b1;
         ring_osc_en_q <= 1'b0;
         stop_q <= 1'b0;
      end else begin
         xtal_osc_en_q <= (state_d != ST_STOP); // [RULE_01]
         ring_osc_en_q <= (state_d == ST_RUN_RING); // [RULE_06]
         stop_q <= (state_d == ST_STOP);
      end
   end

   // Registered core tick, and the processor tick that idle holds back.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         core_clk_en_q <= 1'b0;
         cpu_clk_en_q <= 1'b0;
      end else begin
         core_clk_en_q <= core_tick;
         cpu_clk_en_q <= core_tick && !pwr_ctrl_q[IDLE_BIT];
      end
   end

   // Machine-cycle divider gives the address-latch strobe.
   tick_div_if mc_div ();
   assign mc_div.step = core_tick;
   assign mc_div.restart = (state_q == ST_STOP);
   assign mc_div.period = MACHINE_CYCLE_CLOCKS; // [RULE_09]

   tick_divider mc_divider (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .div(mc_div)
   );

   // One timer-rate divider per timer, each with its own rate select.
   for (genvar t = 0; t < TIMER_COUNT; t++) begin : g_timer
      tick_div_if tm_div ();
      assign tm_div.step = core_tick;
      assign tm_div.restart = (state_q == ST_STOP);
      assign tm_div.period = clk_ctrl_q[TIMER0_RATE_BIT + t] ?
         TIMER_FAST_CLOCKS : TIMER_SLOW_CLOCKS; // [RULE_10]
      assign timer_pulse[t] = tm_div.pulse;

      tick_divider tm_divider (
         .clk_i(clk_i),
         .reset_i(reset_i),
         .div(tm_div)
      );
   end

   // Output drivers; every one of them is a flip-flop.
   assign sfr_rdata_o = rdata_q;
   assign xtal_osc_en_o = xtal_osc_en_q;
   assign ring_osc_en_o = ring_osc_en_q;
   assign core_clk_en_o = core_clk_en_q;
   assign cpu_clk_en_o = cpu_clk_en_q;
   assign core_on_ring_o = ring_flag_q;
   assign stop_o = stop_q;
   assign ale_o = mc_div.pulse;
   assign timer_tick_o = timer_pulse;
endmodule

// *** tb/osc_model.sv ***
// Crystal and ring oscillator model for the clock selector's far side.
`timescale 1ns/1ps
module osc_model (
   input wire logic clk_i,
   input wire logic xtal_en_i,
   input wire logic ring_en_i,
   output logic xtal_o,
   output logic ring_o
);
   logic [2:0] cnt_q = 3'h0;

   // A disabled oscillator stands still low; crystal period 8 cycles, ring period 4.
   always_ff @(posedge clk_i) begin
      cnt_q <= cnt_q + 3'h1;
      xtal_o <= xtal_en_i ? cnt_q[2] : 1'h0;
      ring_o <= ring_en_i ? cnt_q[1] : 1'h0;
   end
endmodule

// *** tb/swr_assertions.sv ***
// Concurrent checks on the ports of the stop-state clock selector.
`timescale 1ns/1ps
module swr_assertions #(
   parameter int unsigned WARMUP_CLOCKS = 16
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic wake_irq_i,
   input wire logic xtal_i,
   input wire logic ring_i,
   input wire logic xtal_osc_en_o,
   input wire logic ring_osc_en_o,
   input wire logic core_clk_en_o,
   input wire logic cpu_clk_en_o,
   input wire logic core_on_ring_o,
   input wire logic stop_o,
   input wire logic ale_o,
   input wire logic [clk_pkg::TIMER_COUNT-1:0] timer_tick_o
);
   import clk_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);

   // Stop, wake and handover behaviour of the oscillators, and spacing of the ticks.
   chk_stop_osc_off: assert property (stop_o |-> !xtal_osc_en_o && !ring_osc_en_o)
      else $error("oscillator enabled while stopped");
   chk_stop_no_ticks: assert property ($past(stop_o) && stop_o |-> !core_clk_en_o)
      else $error("core tick while stopped");
   chk_wake_leaves_stop: assert property (stop_o && wake_irq_i |=> !stop_o && xtal_osc_en_o)
      else $error("wake did not leave stop");
   chk_ring_from_wake: assert property ($rose(ring_osc_en_o) |-> $past(stop_o) && $past(wake_irq_i))
      else $error("ring started without interrupt wake");
   chk_restop_all_off: assert property (sfr_wr_i && sfr_addr_i == PWR_CTRL_ADDR
      && sfr_wdata_i[STOP_BIT] && !stop_o |=> stop_o && !ring_osc_en_o && !core_on_ring_o)
      else $error("stop write left a clock running");
   chk_ring_flag_set: assert property (ring_osc_en_o |-> core_on_ring_o)
      else $error("ring running without ring flag");
   chk_ale_spacing: assert property (ale_o |=> !ale_o [*3])
      else $error("address latch pulses too close");
   chk_ale_on_tick: assert property (ale_o |-> core_clk_en_o)
      else $error("address latch pulse without core tick");
   chk_timer_on_tick: assert property (|timer_tick_o |-> core_clk_en_o)
      else $error("timer tick without core tick");
   chk_handover_done: assert property ($fell(core_on_ring_o) && !stop_o
      |-> xtal_osc_en_o && !ring_osc_en_o)
      else $error("ring flag cleared before crystal took over");

   // Crystal pin edges seen during a ring run; the run must end soon after the count.
   logic xtal_pin_q;
   int unsigned ring_xtal_cnt_q;
   always_ff @(posedge clk_i) begin
      xtal_pin_q <= xtal_i;
      if (reset_i || !core_on_ring_o) begin
         ring_xtal_cnt_q <= 0;
      end else if (xtal_i && !xtal_pin_q) begin
         ring_xtal_cnt_q <= ring_xtal_cnt_q + 1;
      end
   end
   chk_ring_run_bounded: assert property (core_on_ring_o |-> ring_xtal_cnt_q <= WARMUP_CLOCKS + 2)
      else $error("ring run outlived the crystal count");

   // Main scenarios reached.
   cover property (stop_o && wake_irq_i);
   cover property ($fell(core_on_ring_o) && !stop_o);
   cover property (ale_o && timer_tick_o[0]);
endmodule

bind stop_wake_ring_clock_select swr_assertions #(.WARMUP_CLOCKS(WARMUP_CLOCKS)) chk (.*);

// *** tb/tb_top.sv ***
// Self-checking testbench for the stop-state clock selector.
`timescale 1ns/1ps
module tb_top;
   import clk_pkg::*;
   localparam int W = 16;
   logic clk_i = 1'h0, reset_i = 1'h1, sfr_wr_i = 1'h0, sfr_rd_i = 1'h0, wake_irq_i = 1'h0;
   logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
   logic xtal_i, ring_i, xtal_osc_en_o, ring_osc_en_o, core_clk_en_o, core_on_ring_o;
   logic stop_o, ale_o, cpu_clk_en_o, xtal_d_q = 1'h0;
   logic [TIMER_COUNT-1:0] timer_tick_o;
   int num_errors = 0, tests_run = 0, xtal_edges = 0, cpu_ticks = 0, e0, n, k, m;

   stop_wake_ring_clock_select #(.WARMUP_CLOCKS(W)) dut (.clk_i(clk_i), .reset_i(reset_i),
      .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
      .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o), .wake_irq_i(wake_irq_i),
      .xtal_i(xtal_i), .ring_i(ring_i), .xtal_osc_en_o(xtal_osc_en_o),
      .ring_osc_en_o(ring_osc_en_o), .core_clk_en_o(core_clk_en_o),
      .cpu_clk_en_o(cpu_clk_en_o), .core_on_ring_o(core_on_ring_o), .stop_o(stop_o),
      .ale_o(ale_o), .timer_tick_o(timer_tick_o));
   osc_model osc (.clk_i(clk_i), .xtal_en_i(xtal_osc_en_o), .ring_en_i(ring_osc_en_o),
      .xtal_o(xtal_i), .ring_o(ring_i));

   // Clock, a count of crystal edges seen on the pin and a count of processor ticks.
   initial forever #25 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      xtal_d_q <= xtal_i;
      if (xtal_i && !xtal_d_q) xtal_edges <= xtal_edges + 1;
      if (cpu_clk_en_o === 1'h1) cpu_ticks <= cpu_ticks + 1;
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   // One cycle of waiting under a bound of 5000 steps since k was last cleared.
   task automatic step;
      @(posedge clk_i);
      #1;
      k++;
      if (k > 5000) begin
         num_errors++;
         test_done();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_wr_i <= 1'h1;
      @(posedge clk_i);
      sfr_wr_i <= 1'h0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk_i);
      sfr_addr_i <= a;
      sfr_rd_i <= 1'h1;
      @(posedge clk_i);
      sfr_rd_i <= 1'h0;
      #1;
      check(what, sfr_rdata_o, exp);
   endtask

   task automatic wake;
      @(posedge clk_i);
      wake_irq_i <= 1'h1;
      @(posedge clk_i);
      wake_irq_i <= 1'h0;
      #1;
      e0 = xtal_edges;
   endtask

   function automatic logic sel(input int i);
      return (i == 3) ? ale_o : timer_tick_o[i];
   endfunction

   // Counts core ticks from one pulse of the chosen divider output to the next.
   task automatic gap(input int i, input logic [7:0] exp, input string what);
      k = 0;
      do step(); while (sel(i) !== 1'h1);
      n = 0;
      do begin
         step();
         n = n + int'(core_clk_en_o);
      end while (sel(i) !== 1'h1);
      check(what, n[7:0], exp);
   endtask

   // Main sequence; ring-clocked stretches carry only register accesses.
   initial begin
      repeat (16) @(posedge clk_i);
      reset_i <= 1'h0;
      rd(EXT_FLAG_ADDR, 8'h00, "ext flags reset");
      rd(CLK_CTRL_ADDR, CLK_CTRL_RESET, "clock ctrl reset");
      rd(8'h90, 8'h00, "unmapped read");
      wr(EXT_FLAG_ADDR, 8'hFF);
      rd(EXT_FLAG_ADDR, 8'hF3, "ext flags write");
      $display("test registers done");
      gap(3, 8'h04, "ale period");
      for (int i = 0; i < 3; i++) begin
         gap(i, 8'h0C, "timer slow");
         wr(CLK_CTRL_ADDR, 8'h01 | (8'h08 << i));
         gap(i, 8'h04, "timer fast");
         wr(CLK_CTRL_ADDR, 8'h01);
      end
      $display("test dividers done");
      // Idle holds the processor tick back while core ticks go on; a wake lifts it.
      wr(PWR_CTRL_ADDR, 8'h01);
      rd(PWR_CTRL_ADDR, 8'h01, "idle set");
      m = cpu_ticks;
      gap(3, 8'h04, "ale in idle");
      check("cpu ticks in idle", 8'(cpu_ticks - m), 8'h00);
      wake();
      rd(PWR_CTRL_ADDR, 8'h00, "idle cleared");
      m = cpu_ticks;
      gap(3, 8'h04, "ale after idle");
      check("cpu ticks after idle", {7'h00, cpu_ticks - m >= 4}, 8'h01);
      $display("test idle done");
      wr(EXT_FLAG_ADDR, 8'h00);
      wr(PWR_CTRL_ADDR, 8'h02);
      #1;
      check("stop", {5'h00, stop_o, xtal_osc_en_o, ring_osc_en_o}, 8'h04);
      wake();
      check("crystal wake", {5'h00, stop_o, xtal_osc_en_o, core_on_ring_o}, 8'h02);
      k = 0;
      while (core_clk_en_o !== 1'h1) step();
      check("crystal warmup", {7'h00, xtal_edges - e0 >= W}, 8'h01);
      rd(PWR_CTRL_ADDR, 8'h00, "stop bit cleared");
      $display("test crystal wake done");
      wr(EXT_FLAG_ADDR, 8'h02);
      wr(PWR_CTRL_ADDR, 8'h02);
      wake();
      check("ring wake", {4'h0, stop_o, xtal_osc_en_o, ring_osc_en_o, core_on_ring_o},
         8'h07);
      rd(EXT_FLAG_ADDR, 8'h06, "ring flag read");
      wr(PWR_CTRL_ADDR, 8'h02);
      #1;
      check("restop", {5'h00, stop_o, ring_osc_en_o, core_on_ring_o}, 8'h04);
      wake();
      k = 0;
      while (core_on_ring_o !== 1'h0) step();
      n = xtal_edges - e0;
      check("handover count", {7'h00, n >= W && n <= W + 2}, 8'h01);
      check("handover ring off", {7'h00, ring_osc_en_o}, 8'h00);
      rd(EXT_FLAG_ADDR, 8'h02, "flag after handover");
      $display("test ring wake done");
      // A reset in the middle of a ring run returns to the crystal with ring select clear.
      wr(PWR_CTRL_ADDR, 8'h02);
      wake();
      @(posedge clk_i);
      reset_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'h0;
      #1;
      check("reset in ring", {5'h00, xtal_osc_en_o, ring_osc_en_o, core_on_ring_o}, 8'h04);
      rd(EXT_FLAG_ADDR, 8'h00, "select after reset");
      $display("test reset done");
      test_done();
   end
endmodule
